// ==== core/remap_pkg.sv ====
// shared constants and types of the display address and remap controller
package remap_pkg;

  localparam logic [7:0] CMD_COL_WINDOW = 8'h15;
  localparam logic [7:0] CMD_ROW_WINDOW = 8'h75;
  localparam logic [7:0] CMD_PRECHARGE_SPEED = 8'h8a;
  localparam logic [7:0] CMD_REMAP = 8'ha0;
  localparam logic [7:0] CMD_START_LINE = 8'ha1;
  localparam logic [7:0] CMD_OFFSET = 8'ha2;
  localparam logic [7:0] CMD_MUX_RATIO = 8'ha8;

  localparam logic [7:0] COL_LAST = 8'h9f;
  localparam logic [7:0] ROW_LAST = 8'h83;
  localparam logic [8:0] COM_COUNT = 9'h084;
  localparam logic [7:0] COM_HALF = 8'h42;
  localparam logic [7:0] MUX_MIN_M1 = 8'h0f;

  localparam logic [7:0] RST_REMAP = 8'h40;
  localparam logic [7:0] RST_START_LINE = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_MUX_M1 = 8'h83;
  localparam logic [7:0] RST_PRECHARGE_SPEED = 8'h00;

  // field layout follows the parameter byte bit for bit
  typedef struct packed {
    logic [1:0] colourDepth;
    logic splitOddEven;
    logic scanReverse;
    logic comRightFirst;
    logic colourSwap;
    logic segMirror;
    logic vertIncr;
  } remap_cfg_t;

  typedef struct packed {
    logic [7:0] startLine;
    logic [7:0] offset;
    logic [7:0] muxM1;
  } scan_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_P1 = 3'b010,
    ST_P2 = 3'b100
  } parse_state_t;

  function automatic logic [7:0] mod_com(input logic [8:0] v);
    mod_com = (v >= COM_COUNT) ? 8'(v - COM_COUNT) : v[7:0];
  endfunction : mod_com

endpackage : remap_pkg

// ==== core/com_line_mapper.sv ====
// maps one scan step to its common output, ram row and enable
`timescale 1ns/1ps
`default_nettype none
module com_line_mapper
  import remap_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] scanStep,
  input wire remap_cfg_t remapCfg,
  input wire scan_cfg_t scanCfg,
  output logic [7:0] comPin,
  output logic [7:0] rowShown,
  output logic comActive
);

  wire logic [7:0] logicalCom;
  wire logic [7:0] linePos;
  wire logic [7:0] splitPin;
  wire logic [7:0] next_comPin;
  wire logic [7:0] next_rowShown;
  wire logic next_comActive;

  assign logicalCom = remapCfg.scanReverse ? 8'(ROW_LAST - scanStep) : scanStep;
  assign linePos = mod_com({1'b0, logicalCom} + {1'b0, scanCfg.offset});
  assign next_comActive = (linePos <= scanCfg.muxM1);
  assign next_rowShown = mod_com({1'b0, scanCfg.startLine} + {1'b0, linePos});
  // split sends the lower half to even rows and the upper half to odd rows
  assign splitPin = (logicalCom < COM_HALF) ? 8'(logicalCom << 1)
                  : 8'(((logicalCom - COM_HALF) << 1) | 8'h01);
  assign next_comPin = remapCfg.comRightFirst
                     ? 8'(ROW_LAST - (remapCfg.splitOddEven ? splitPin : logicalCom))
                     : (remapCfg.splitOddEven ? splitPin : logicalCom);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      comPin <= 8'h00;
      rowShown <= 8'h00;
      comActive <= 1'b0;
    end else begin
      comPin <= next_comPin;
      rowShown <= next_rowShown;
      comActive <= next_comActive;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  chk_mux_blanks_line: assert property (
    (linePos > scanCfg.muxM1) |=> !comActive)
    else $error("common line outside multiplex range was enabled");

  chk_offset_sixteen: assert property (
    (scanCfg.offset == 8'h10 && scanCfg.startLine == 8'h00 && !remapCfg.scanReverse
     && scanStep == 8'h00) |=> rowShown == 8'h10)
    else $error("offset of sixteen did not shift rows by sixteen");

  chk_split_even_rows: assert property (
    (remapCfg.splitOddEven && !remapCfg.comRightFirst && !remapCfg.scanReverse
     && scanStep < COM_HALF) |=> comPin == 8'($past(scanStep) << 1))
    else $error("split mode did not map lower half to even rows");

  chk_scan_reverse: assert property (
    (remapCfg.scanReverse && !remapCfg.splitOddEven && !remapCfg.comRightFirst)
    |=> comPin == 8'(ROW_LAST - $past(scanStep)))
    else $error("reverse scan did not run from the last common line");

endmodule : com_line_mapper
`default_nettype wire

// ==== core/display_address_remap_ctrl.sv ====
// command parser, ram address pointers and remap settings of the display
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - horizontal mode: column steps, wraps, row advances
// - vertical mode: row steps, wraps, column advances
// - mirror bit picks column 0 or 159
// - swap bit reorders colour components; here only stored in remapCfg
// - left/right bit mirrors common arrangement
// - scan bit reverses common scan order
// - no split: common n drives row n
// - split: lower half even rows, upper odd
// - depth field selects 65k or 256 colours; here only stored in remapCfg
// - start line picks first row, wraps 132
// - offset moves start line to any common
// - offset 16 shifts lines sixteen positions
// - stores second pre-charge speed setting
// - multiplex ratio 16 to 132, default 132
// - column window also loads column pointer
module display_address_remap_ctrl
  import remap_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] hostByte,
  input wire logic hostDataSel,
  input wire logic hostStrobe,
  input wire logic ramAccess,
  input wire logic lineTick,
  output logic [7:0] colPtr,
  output logic [7:0] rowPtr,
  output remap_cfg_t remapCfg,
  output scan_cfg_t scanCfg,
  output logic [7:0] prechargeSpeed,
  output logic [7:0] firstSegColumn,
  output logic [7:0] scanStep,
  output logic [7:0] comPin,
  output logic [7:0] rowShown,
  output logic comActive
);

  parse_state_t state;
  parse_state_t next_state;
  logic [7:0] opcode;
  logic [7:0] colStart;
  logic [7:0] colEnd;
  logic [7:0] rowStart;
  logic [7:0] rowEnd;
  logic [7:0] firstParam;

  wire logic cmdTake;
  wire logic paramTake;
  wire logic twoParams;
  wire logic oneParam;
  wire logic lastParam;
  wire logic colAtEnd;
  wire logic rowAtEnd;
  wire logic [7:0] colStep;
  wire logic [7:0] rowStep;
  wire logic [7:0] next_colPtr;
  wire logic [7:0] next_rowPtr;
  wire logic [7:0] muxClamped;
  wire logic colWindowDone;
  wire logic rowWindowDone;

  // the select line tells opcode from parameter; a stray parameter is ignored
  assign cmdTake = hostStrobe && !hostDataSel;
  assign paramTake = hostStrobe && hostDataSel && (state != ST_IDLE);
  assign twoParams = (hostByte == CMD_COL_WINDOW) || (hostByte == CMD_ROW_WINDOW);
  assign oneParam = (hostByte == CMD_PRECHARGE_SPEED) || (hostByte == CMD_REMAP)
                 || (hostByte == CMD_START_LINE) || (hostByte == CMD_OFFSET)
                 || (hostByte == CMD_MUX_RATIO);
  assign lastParam = paramTake && ((state == ST_P2)
                  || (state == ST_P1 && opcode != CMD_COL_WINDOW && opcode != CMD_ROW_WINDOW));
  assign colWindowDone = paramTake && (state == ST_P2) && (opcode == CMD_COL_WINDOW);
  assign rowWindowDone = paramTake && (state == ST_P2) && (opcode == CMD_ROW_WINDOW);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmdTake && (twoParams || oneParam)) begin
          next_state = ST_P1;
        end
      end
      ST_P1: begin
        if (cmdTake) begin
          next_state = (twoParams || oneParam) ? ST_P1 : ST_IDLE;
        end else if (paramTake) begin
          next_state = lastParam ? ST_IDLE : ST_P2;
        end
      end
      ST_P2: begin
        if (cmdTake) begin
          next_state = (twoParams || oneParam) ? ST_P1 : ST_IDLE;
        end else if (paramTake) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      opcode <= 8'h00;
      firstParam <= 8'h00;
    end else begin
      state <= next_state;
      if (cmdTake) begin
        opcode <= hostByte;
      end
      if (paramTake && state == ST_P1) begin
        firstParam <= hostByte;
      end
    end
  end

  // pointer stepping; out-of-range ends clip to the ram edge
  assign colAtEnd = (colPtr == colEnd) || (colPtr >= COL_LAST);
  assign rowAtEnd = (rowPtr == rowEnd) || (rowPtr >= ROW_LAST);
  assign colStep = colAtEnd ? colStart : 8'(colPtr + 8'h01);
  assign rowStep = rowAtEnd ? rowStart : 8'(rowPtr + 8'h01);
  assign next_colPtr = !remapCfg.vertIncr ? colStep
                     : (rowAtEnd ? colStep : colPtr);
  assign next_rowPtr = remapCfg.vertIncr ? rowStep
                     : (colAtEnd ? rowStep : rowPtr);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      colStart <= 8'h00;
      colEnd <= COL_LAST;
      rowStart <= 8'h00;
      rowEnd <= ROW_LAST;
      colPtr <= 8'h00;
      rowPtr <= 8'h00;
    end else if (colWindowDone) begin
      colStart <= firstParam;
      colEnd <= hostByte;
      colPtr <= firstParam;
    end else if (rowWindowDone) begin
      rowStart <= firstParam;
      rowEnd <= hostByte;
      rowPtr <= firstParam;
    end else if (ramAccess) begin
      colPtr <= next_colPtr;
      rowPtr <= next_rowPtr;
    end
  end

  // multiplex setting below 16 lines is raised, above 132 lowered
  assign muxClamped = (hostByte < MUX_MIN_M1) ? MUX_MIN_M1
                    : ((hostByte > ROW_LAST) ? ROW_LAST : hostByte);

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      remapCfg <= remap_cfg_t'(RST_REMAP);
      scanCfg <= '{RST_START_LINE, RST_OFFSET, RST_MUX_M1};
      prechargeSpeed <= RST_PRECHARGE_SPEED;
      firstSegColumn <= 8'h00;
    end else begin
      firstSegColumn <= remapCfg.segMirror ? COL_LAST : 8'h00;
      if (lastParam) begin
        case (opcode)
          CMD_REMAP: remapCfg <= remap_cfg_t'(hostByte);
          CMD_START_LINE: begin
            if (hostByte <= ROW_LAST) begin
              scanCfg.startLine <= hostByte;
            end
          end
          CMD_OFFSET: begin
            if (hostByte <= ROW_LAST) begin
              scanCfg.offset <= hostByte;
            end
          end
          CMD_MUX_RATIO: scanCfg.muxM1 <= muxClamped;
          CMD_PRECHARGE_SPEED: prechargeSpeed <= hostByte;
          default: ;
        endcase
      end
    end
  end

  // frame scan counter; one line per tick, wrapping after the last common
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      scanStep <= 8'h00;
    end else if (lineTick) begin
      scanStep <= (scanStep >= ROW_LAST) ? 8'h00 : 8'(scanStep + 8'h01);
    end
  end

  com_line_mapper mapper (
    .mclk(mclk),
    .rst_b(rst_b),
    .scanStep(scanStep),
    .remapCfg(remapCfg),
    .scanCfg(scanCfg),
    .comPin(comPin),
    .rowShown(rowShown),
    .comActive(comActive)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_horiz_step;
    ramAccess && !colWindowDone && !rowWindowDone && !remapCfg.vertIncr;
  endsequence

  sequence s_vert_step;
    ramAccess && !colWindowDone && !rowWindowDone && remapCfg.vertIncr;
  endsequence

  chk_col_advance: assert property (
    s_horiz_step ##0 !colAtEnd |=> colPtr == 8'($past(colPtr) + 8'h01) && $stable(rowPtr))
    else $error("column pointer did not step by one");

  chk_col_wrap: assert property (
    s_horiz_step ##0 colAtEnd && !rowAtEnd
    |=> colPtr == $past(colStart) && rowPtr == 8'($past(rowPtr) + 8'h01))
    else $error("column wrap did not reload start and advance row");

  chk_row_advance: assert property (
    s_vert_step ##0 !rowAtEnd |=> rowPtr == 8'($past(rowPtr) + 8'h01) && $stable(colPtr))
    else $error("row pointer did not step by one");

  chk_row_wrap: assert property (
    s_vert_step ##0 rowAtEnd && !colAtEnd
    |=> rowPtr == $past(rowStart) && colPtr == 8'($past(colPtr) + 8'h01))
    else $error("row wrap did not reload start and advance column");

  chk_window_load: assert property (
    colWindowDone |=> colPtr == $past(firstParam) && colStart == colPtr)
    else $error("column window did not load the column pointer");

  // compare with the bit one cycle back; a later remap write may already stand
  chk_seg_first: assert property (
    $changed(remapCfg.segMirror)
    |=> firstSegColumn == ($past(remapCfg.segMirror) ? COL_LAST : 8'h00))
    else $error("first segment column does not follow mirror bit");

endmodule : display_address_remap_ctrl
`default_nettype wire

// ==== test/host_model.sv ====
// host side model that sends command and parameter bytes to the controller
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic mclk,
  output var logic [7:0] hostByte,
  output var logic hostDataSel,
  output var logic hostStrobe
);
  initial begin
    hostByte = 8'h00;
    hostDataSel = 1'b0;
    hostStrobe = 1'b0;
  end
  task automatic put(input logic [7:0] b, input logic sel);
    @(posedge mclk);
    #1;
    hostByte = b;
    hostDataSel = sel;
    hostStrobe = 1'b1;
  endtask : put
  // opcode first with select low, then its parameters back to back
  task automatic send(input logic [7:0] op, input int n,
                      input logic [7:0] p0, input logic [7:0] p1);
    put(op, 1'b0);
    if (n > 0) put(p0, 1'b1);
    if (n > 1) put(p1, 1'b1);
    @(posedge mclk);
    #1;
    hostStrobe = 1'b0;
    // a released bus must not keep showing the last byte
    hostByte = ~hostByte;
    @(posedge mclk);
  endtask : send
endmodule : host_model
`default_nettype wire

// ==== test/display_address_remap_ctrl_tb.sv ====
// self-checking bench of the address pointers, remap settings and scan mapping
`timescale 1ns/1ps
`default_nettype none
module display_address_remap_ctrl_tb
  import remap_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic ramAccess = 1'b0;
  logic lineTick = 1'b0;
  logic [7:0] hostByte, colPtr, rowPtr, prechargeSpeed, firstSegColumn, scanStep, comPin, rowShown;
  logic hostDataSel, hostStrobe, comActive;
  remap_cfg_t remapCfg;
  scan_cfg_t scanCfg;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;

  always #20 mclk = ~mclk;

  host_model hm (.mclk(mclk), .hostByte(hostByte), .hostDataSel(hostDataSel),
    .hostStrobe(hostStrobe));

  display_address_remap_ctrl DUT (.mclk(mclk), .rst_b(rst_b), .hostByte(hostByte),
    .hostDataSel(hostDataSel), .hostStrobe(hostStrobe), .ramAccess(ramAccess),
    .lineTick(lineTick), .colPtr(colPtr), .rowPtr(rowPtr), .remapCfg(remapCfg),
    .scanCfg(scanCfg), .prechargeSpeed(prechargeSpeed), .firstSegColumn(firstSegColumn),
    .scanStep(scanStep), .comPin(comPin), .rowShown(rowShown), .comActive(comActive));

  task automatic results();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // the whole run needs about 2400 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      $display("ERROR at %0t: run hung", $time);
      results();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // n consecutive accesses, then one cycle for the pointers to settle
  task automatic access(input int n);
    @(posedge mclk);
    #1;
    ramAccess = 1'b1;
    repeat (n) @(posedge mclk);
    #1;
    ramAccess = 1'b0;
    @(posedge mclk);
    #1;
  endtask : access

  task automatic test_reset();
    chk(24'(remapCfg), 24'h000040, "remap");
    chk(scanCfg, 24'h000083, "scan cfg");
    chk(24'(prechargeSpeed), 24'h0, "speed");
    chk(24'({colPtr, rowPtr}), 24'h0, "pointers");
  endtask : test_reset

  task automatic test_horiz();
    hm.send(CMD_COL_WINDOW, 2, 8'h02, 8'h9d);
    hm.send(CMD_ROW_WINDOW, 2, 8'h01, 8'h82);
    chk(24'({colPtr, rowPtr}), 24'h0201, "window load");
    access(155);
    chk(24'({colPtr, rowPtr}), 24'h9d01, "column end");
    access(1);
    chk(24'({colPtr, rowPtr}), 24'h0202, "column wrap");
  endtask : test_horiz

  task automatic test_vert();
    hm.send(CMD_REMAP, 1, 8'h41, 8'h00);
    hm.send(CMD_ROW_WINDOW, 2, 8'h01, 8'h82);
    access(129);
    chk(24'({colPtr, rowPtr}), 24'h0282, "row end");
    access(1);
    chk(24'({colPtr, rowPtr}), 24'h0301, "row wrap");
  endtask : test_vert

  task automatic test_fields();
    logic [7:0] v [4] = '{8'h42, 8'h84, 8'h88, 8'h00};
    foreach (v[i]) begin
      hm.send(CMD_REMAP, 1, v[i], 8'h00);
      #1;
      chk(24'(remapCfg), 24'(v[i]), "remap field");
      chk(24'(firstSegColumn), v[i][1] ? 24'd159 : 24'd0, "first column");
    end
    // a remap opcode left pending must be dropped by the next opcode
    hm.send(CMD_REMAP, 0, 8'h00, 8'h00);
    hm.send(CMD_PRECHARGE_SPEED, 1, 8'h5a, 8'h00);
    hm.send(CMD_START_LINE, 1, 8'h84, 8'h00);
    #1;
    chk(24'(remapCfg), 24'h0, "aborted remap");
    chk(24'(prechargeSpeed), 24'h5a, "speed");
    chk(24'(scanCfg.startLine), 24'h0, "start line out of range");
    hm.send(CMD_MUX_RATIO, 1, 8'h05, 8'h00);
    #1;
    chk(24'(scanCfg.muxM1), 24'(MUX_MIN_M1), "mux floor");
    hm.send(CMD_MUX_RATIO, 1, 8'hff, 8'h00);
    #1;
    chk(24'(scanCfg.muxM1), 24'(ROW_LAST), "mux ceiling");
  endtask : test_fields

  // one full frame of 132 lines under the given remap and scan settings
  task automatic scan(input logic [7:0] rm, input int st, input int off, input int mx);
    int c, pos, pin;
    hm.send(CMD_REMAP, 1, rm, 8'h00);
    hm.send(CMD_START_LINE, 1, 8'(st), 8'h00);
    hm.send(CMD_OFFSET, 1, 8'(off), 8'h00);
    hm.send(CMD_MUX_RATIO, 1, 8'(mx), 8'h00);
    repeat (2) @(posedge mclk);
    #1;
    for (int s = 0; s < 132; s++) begin
      c = rm[4] ? 131 - s : s;
      pos = (c + off) % 132;
      pin = rm[5] ? (c < 66 ? 2 * c : 2 * (c - 66) + 1) : c;
      pin = rm[3] ? 131 - pin : pin;
      chk(24'(scanStep), 24'(s), "step");
      chk(24'(comActive), 24'(pos <= mx), "active");
      chk(24'(rowShown), 24'((st + pos) % 132), "row");
      chk(24'(comPin), 24'(pin), "pin");
      lineTick = 1'b1;
      @(posedge mclk);
      #1;
      lineTick = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
    end
  endtask : scan

  initial begin
    repeat (3) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    test_reset();
    test_horiz();
    test_vert();
    test_fields();
    scan(8'h40, 0, 0, 131);
    scan(8'h40, 0, 16, 131);
    scan(8'h60, 32, 16, 99);
    scan(8'h50, 0, 16, 131);
    scan(8'h48, 5, 131, 15);
    results();
  end
endmodule : display_address_remap_ctrl_tb
`default_nettype wire
